// File: verilog/eoc_pkg.sv
// Purpose: constants for the external oscillator control block
// Assumes: avalon-mm word addressing, 32-bit data, 25 MHz ref_clk
// Notes:   control register sits in the low byte of its word
package eoc_pkg;
  // register map (word addresses)
  localparam logic [3:0] CtrlAddr   = 4'h0;
  localparam logic [3:0] IrqStatAddr = 4'h1;
  localparam logic [3:0] IrqMaskAddr = 4'h2;
  localparam logic [7:0] CtrlPage   = 8'h00;
  localparam logic [7:0] CtrlSfrAddr = 8'hb1;
  // control field positions
  localparam int ValidBit  = 7;
  localparam int ModeHi    = 6;
  localparam int ModeLo    = 4;
  localparam int ResvBit   = 3;
  localparam int DriveHi   = 2;
  localparam int DriveLo   = 0;
  localparam logic [7:0] CtrlReset = 8'h00;
  localparam logic [7:0] CtrlWrMask = 8'h77;
  // interrupt status bits
  localparam int IrqValidRise = 0;
  localparam int IrqValidFall = 1;
  localparam logic [1:0] IrqReset = 2'h0;
  // stability detector: edges of the oscillator needed to call it stable
  localparam logic [7:0] StableEdges = 8'hff;
  // oscillator modes
  typedef enum logic [2:0] {
    EocOff0    = 3'h0,
    EocOff1    = 3'h1,
    EocCmos    = 3'h2,
    EocCmosDiv = 3'h3,
    EocRc      = 3'h4,
    EocCap     = 3'h5,
    EocXtal    = 3'h6,
    EocXtalDiv = 3'h7
  } eoc_mode_t;
endpackage : eoc_pkg

// File: verilog/eoc_stable_det.sv
// Purpose: judges when the sampled oscillator has toggled long enough
// Assumes: oscIn already synchronised to ref_clk
// Notes:   any disable restarts the count
`timescale 1ns/1ns
`default_nettype none
module eoc_stable_det (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // control
  input  wire logic       enable,
  input  wire logic       oscIn,
  // status
  output logic            stable
);
  logic [7:0] edgeCnt_q;
  logic       oscPrev_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oscPrev_q <= 1'b0;
    end else begin
      oscPrev_q <= oscIn;
    end
  end

  // counting edges rather than time: slow rc clocks still qualify
  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      edgeCnt_q <= 8'h00;
    end else if (oscIn && !oscPrev_q &&
                 edgeCnt_q != eoc_pkg::StableEdges) begin
      edgeCnt_q <= edgeCnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      stable <= 1'b0;
    end else begin
      stable <= (edgeCnt_q == eoc_pkg::StableEdges);
    end
  end
endmodule : eoc_stable_det
`default_nettype wire

// File: verilog/eoc_ctrl.sv
// Purpose: external oscillator control and status register
// Assumes: oscillator pin and its analog front end are outside
// Notes:   divided clock is a ref_clk-domain enable-style toggle
//
// Function
// - bit 7 reads 1 when the oscillator runs and is stable.
// - in either external clock input mode the valid flag reads 0.
// - mode 00x disables; 010 clock input; 011 clock input halved.
// - 100 rc, 101 capacitor, 110 crystal, 111 crystal halved.
// - bit 3 reserved, reads 0; software writes 0.
// - bits 2:0 set the oscillator bias drive level, eight settings.
// - register at page 0 address 0xb1, all bits clear on reset.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module eoc_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // oscillator pin side
  input  wire logic        extOscIn,
  output logic             extOscEnable,
  output logic [2:0]       extOscModeSel,
  output logic [2:0]       extOscDriveLevel,
  output logic             extOscClkOut,
  // interrupt
  output logic             irq
);
  logic [2:0] ext_osc_mode_sel_q;
  logic [2:0] ext_osc_drive_level_q;
  logic       irqRise_q;
  logic       irqFall_q;
  logic [1:0] irqStat;
  logic [1:0] irqMask_q;
  logic       oscMeta_q;
  logic       oscSync_q;
  logic       oscSyncPrev_q;
  logic       halfClk_q;
  logic       clkOut_q;
  logic       rdPend_q;
  logic       stable;
  logic       ext_osc_valid_flag;
  logic       validPrev_q;
  logic       validRise;
  logic       validFall;
  logic       oscRise;
  logic       modeCmos;
  logic       modeOn;
  logic       modeDiv;
  logic       wrCtrl;
  logic       wrStat;
  logic       wrMask;
  logic [7:0] ctrlView;

  function automatic logic is_cmos(input logic [2:0] m);
    return m == 3'(eoc_pkg::EocCmos) || m == 3'(eoc_pkg::EocCmosDiv);
  endfunction : is_cmos

  function automatic logic wr_hit(input logic wr, input logic lane0,
                                  input logic [3:0] a, input logic [3:0] hit);
    return wr && lane0 && a == hit;
  endfunction : wr_hit

  // hardware set wins over a write-one-to-clear in the same cycle
  function automatic logic sticky_next(input logic cur, input logic set,
                                       input logic clr);
    return set || (cur && !clr);
  endfunction : sticky_next

  assign modeCmos = is_cmos(ext_osc_mode_sel_q);
  assign modeOn   = ext_osc_mode_sel_q[2] || modeCmos;
  assign modeDiv  = ext_osc_mode_sel_q == 3'(eoc_pkg::EocCmosDiv) ||
                    ext_osc_mode_sel_q == 3'(eoc_pkg::EocXtalDiv);

  // writes complete at once; reads take one wait cycle for registered data
  assign waitrequest = read && !rdPend_q;
  assign wrCtrl = wr_hit(write, byteenable[0], address,
                         eoc_pkg::CtrlAddr);
  assign wrStat = wr_hit(write, byteenable[0], address,
                         eoc_pkg::IrqStatAddr);
  assign wrMask = wr_hit(write, byteenable[0], address,
                         eoc_pkg::IrqMaskAddr);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdPend_q <= 1'b0;
    end else begin
      rdPend_q <= read && !rdPend_q;
    end
  end

  // control fields; reserved bit 3 is never stored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_osc_mode_sel_q    <=
        eoc_pkg::CtrlReset[eoc_pkg::ModeHi:eoc_pkg::ModeLo];
      ext_osc_drive_level_q <=
        eoc_pkg::CtrlReset[eoc_pkg::DriveHi:eoc_pkg::DriveLo];
    end else if (wrCtrl) begin
      ext_osc_mode_sel_q    <=
        writedata[eoc_pkg::ModeHi:eoc_pkg::ModeLo];
      ext_osc_drive_level_q <=
        writedata[eoc_pkg::DriveHi:eoc_pkg::DriveLo];
    end
  end

  // two-flop synchroniser on the oscillator pin
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oscMeta_q     <= 1'b0;
      oscSync_q     <= 1'b0;
      oscSyncPrev_q <= 1'b0;
    end else begin
      oscMeta_q     <= extOscIn;
      oscSync_q     <= oscMeta_q;
      oscSyncPrev_q <= oscSync_q;
    end
  end

  eoc_stable_det uStable (
    .ref_clk (ref_clk),
    .srst    (srst),
    .enable  (modeOn && !modeCmos),
    .oscIn   (oscSync_q),
    .stable  (stable)
  );

  assign ext_osc_valid_flag = stable && modeOn && !modeCmos;

  // one pulse per synchronised oscillator rising edge
  assign oscRise = oscSync_q && !oscSyncPrev_q;

  // halve on rising edges; limited to inputs below half of ref_clk
  always_ff @(posedge ref_clk) begin
    if (srst || !modeOn) begin
      halfClk_q <= 1'b0;
    end else if (oscRise) begin
      halfClk_q <= !halfClk_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !modeOn) begin
      clkOut_q <= 1'b0;
    end else begin
      clkOut_q <= modeDiv ? halfClk_q : oscSync_q;
    end
  end

  // valid edges raise sticky events; hardware set wins over w1c
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      validPrev_q <= 1'b0;
    end else begin
      validPrev_q <= ext_osc_valid_flag;
    end
  end

  assign validRise = ext_osc_valid_flag && !validPrev_q;
  assign validFall = !ext_osc_valid_flag && validPrev_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqRise_q <= eoc_pkg::IrqReset[eoc_pkg::IrqValidRise];
    end else begin
      irqRise_q <= sticky_next(irqRise_q, validRise,
                               wrStat && writedata[eoc_pkg::IrqValidRise]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqFall_q <= eoc_pkg::IrqReset[eoc_pkg::IrqValidFall];
    end else begin
      irqFall_q <= sticky_next(irqFall_q, validFall,
                               wrStat && writedata[eoc_pkg::IrqValidFall]);
    end
  end

  // status word in its register layout: b0 rose, b1 fell
  always_comb begin
    irqStat = eoc_pkg::IrqReset;
    irqStat[eoc_pkg::IrqValidRise] = irqRise_q;
    irqStat[eoc_pkg::IrqValidFall] = irqFall_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqMask_q <= eoc_pkg::IrqReset;
    end else if (wrMask) begin
      irqMask_q <= writedata[1:0];
    end
  end

  assign irq = |(irqStat & irqMask_q);

  assign ctrlView = {ext_osc_valid_flag, ext_osc_mode_sel_q,
                     1'b0, ext_osc_drive_level_q};

  // unmapped words read as zero and ignore writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !rdPend_q) begin
      if (address == eoc_pkg::CtrlAddr) begin
        readdata <= {24'h00_0000, ctrlView};
      end else if (address == eoc_pkg::IrqStatAddr) begin
        readdata <= {30'h0000_0000, irqStat};
      end else if (address == eoc_pkg::IrqMaskAddr) begin
        readdata <= {30'h0000_0000, irqMask_q};
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  assign extOscEnable     = modeOn;
  assign extOscModeSel    = ext_osc_mode_sel_q;
  assign extOscDriveLevel = ext_osc_drive_level_q;
  assign extOscClkOut     = clkOut_q;
endmodule : eoc_ctrl
`default_nettype wire

// File: test/eoc_ctrl_sva.sv
// Purpose: port checks for eoc_ctrl
// Assumes: one clock domain
// Notes:   bind at file foot
`timescale 1ns/1ns
`default_nettype none
module eoc_ctrl_sva (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        extOscEnable,
  input wire logic [2:0]  extOscModeSel,
  input wire logic        extOscClkOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic rdCtl;
  assign rdCtl = read && !waitrequest && address == eoc_pkg::CtrlAddr;
  logic [2:0] wrMode;
  assign wrMode = writedata[eoc_pkg::ModeHi:eoc_pkg::ModeLo];
  AST_RD_WAIT: assert property (
    $rose(read) |-> waitrequest ##1 !waitrequest) else $error("rd wait");
  AST_WR_NOWAIT: assert property (
    write |-> !waitrequest) else $error("wr wait");
  AST_RESV: assert property (
    rdCtl |-> !readdata[3]) else $error("reserved set");
  AST_NO_VLD: assert property (
    rdCtl && !extOscModeSel[2] |-> !readdata[7]) else $error("valid set");
  AST_MODE_WR: assert property (
    write && byteenable[0] && address == eoc_pkg::CtrlAddr |=>
    extOscModeSel == $past(wrMode)) else $error("mode lost");
  AST_ENABLE: assert property (
    extOscEnable == |extOscModeSel[2:1]) else $error("enable");
  AST_RST: assert property (
    $fell(srst) |-> !extOscModeSel && !readdata) else $error("reset");
  AST_OFF_CLK: assert property (
    !extOscEnable |=> !extOscClkOut) else $error("clock off");
  cover property (rdCtl && readdata[7]);
  cover property (extOscModeSel == 3'h3 && $rose(extOscClkOut));
  cover property (write && address == 4'h1);
endmodule : eoc_ctrl_sva
bind eoc_ctrl eoc_ctrl_sva u_eoc_ctrl_sva (.*);
`default_nettype wire

// File: test/eoc_osc_model.sv
// Purpose: oscillator or clock source on the pin
// Assumes: runs only while the front end is enabled
// Notes:   idle pin holds the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module eoc_osc_model #(parameter int HalfNs = 200) (
  input  wire logic enable,
  output logic      oscOut
);
  logic osc = 1'b0;
  always #(HalfNs) if (enable) osc = ~osc;
  assign oscOut = enable ? osc : ~osc;
endmodule : eoc_osc_model
`default_nettype wire

// File: test/eoc_ctrl_tb.sv
// Purpose: eoc_ctrl bench
// Assumes: osc far below ref_clk/2
// Notes:   reads stall one cycle
`timescale 1ns/1ns
`default_nettype none
module eoc_ctrl_tb;
  localparam logic [3:0] ctl = eoc_pkg::CtrlAddr;
  localparam logic [3:0] sts = eoc_pkg::IrqStatAddr;
  logic ref_clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
  logic waitrequest, extOscIn, extOscEnable, extOscClkOut, irq;
  logic [2:0] extOscModeSel, extOscDriveLevel;
  logic [3:0] address = 4'h0, byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata, q;
  int fail_count = 0, n_checks = 0, cyc = 0;
  int clkRises = 0, base = 0;
  logic clkPrev = 1'b0;
  always #20 ref_clk = ~ref_clk;
  eoc_ctrl u_eoc_ctrl (.*);
  eoc_osc_model u_eoc_osc_model (.enable(extOscEnable), .oscOut(extOscIn));
  task automatic chk(string nm, logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // waitrequest and readdata taken at the rising edge that ends the wait
  task automatic bus(logic w, logic [3:0] a, logic [31:0] v = 32'h0);
    @(posedge ref_clk);
    {write, read, address, writedata} <= {w, !w, a, v};
    do @(posedge ref_clk); while (waitrequest);
    q = readdata;
    {write, read} <= 2'b00;
  endtask : bus
  task automatic rchk(string nm, logic [3:0] a, logic [31:0] e);
    bus(1'b0, a);
    chk(nm, q, e);
  endtask : rchk
  always @(posedge ref_clk) begin
    clkPrev <= extOscClkOut;
    if (extOscClkOut && !clkPrev) clkRises <= clkRises + 1;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rchk("reset", ctl, 32'h0);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, ctl, {24'h0, 1'b1, m[2:0], 1'b0, ~m[2:0]});
      rchk("ctrl", ctl, {25'h0, m[2:0], 1'b0, ~m[2:0]});
      chk("enable", extOscEnable, |m[2:1]);
      chk("mode", extOscModeSel, m[2:0]);
      chk("drive", extOscDriveLevel, {~m[2:0]});
    end
    byteenable <= 4'he;
    bus(1'b1, ctl, 32'h74);
    byteenable <= 4'hf;
    rchk("unmapped", 4'h9, 32'h0);
    rchk("kept", ctl, 32'h70);
    bus(1'b1, ctl, 32'h42);
    for (int i = 0; i < 1500 && !q[7]; i++) bus(1'b0, ctl);
    chk("valid", q, 32'hc2);
    rchk("status", sts, 32'h1);
    chk("masked", irq, 1'b0);
    bus(1'b1, eoc_pkg::IrqMaskAddr, 32'h1);
    rchk("status", sts, 32'h1);
    chk("irq", irq, 1'b1);
    bus(1'b1, sts, 32'h1);
    rchk("cleared", sts, 32'h0);
    chk("irq off", irq, 1'b0);
    bus(1'b1, ctl, 32'h32);
    rchk("fell", sts, 32'h2);
    chk("fell masked", irq, 1'b0);
    base = clkRises;
    repeat (400) @(posedge ref_clk);
    base = clkRises - base;
    chk("half rate", 32'(base >= 19 && base <= 21), 32'h1);
    rchk("cmos", ctl, 32'h32);
    conclude();
  end
endmodule : eoc_ctrl_tb
`default_nettype wire
